// >>> dcst_timer.v
// Command spacing gate for a controller driving a four-bank DDR2 device
// Contract
// - Two cycles between column commands
// - Write data to read: 4, slow grades 3
// - Read to precharge: 4, slow grades 3
// - Write auto precharge waits recovery plus precharge; code adds RFC_CYC_IN[3:0] to recovery instead
// - Self refresh exit: refresh time plus 10ns
// - Self refresh exit to read: 200 cycles
// - Precharge power down exit: 2 cycles
// - Fast active power down exit: 2 cycles
// - Slow active exit: six minus additive latency
// - Clock enable holds each level 3 cycles
// - ODT command to power down: 3 cycles
// - Power down exit to synchronous ODT: 8
// - Clock runs on after asynchronous enable drop
// - Mode register set to next: 2 cycles
// - Mode bit 12 picks active exit timing
`timescale 1ns/1ps
`default_nettype none
`include "dcst_map.vh"

module dcst_timer (
    input  wire                     CLK_IN,
    input  wire                     RST_N_IN,
    input  wire [`DCST_GRADE_W-1:0] GRADE_IN,
    input  wire [2:0]               AL_IN,
    input  wire [7:0]               RFC_CYC_IN,
    input  wire                     CMD_VALID_IN,
    input  wire [`DCST_CMD_W-1:0]   CMD_IN,
    input  wire [13:0]              CMD_ADDR_IN,
    input  wire                     PD_ACTIVE_IN,
    input  wire                     WDATA_LAST_IN,
    output reg                      CMD_READY_OUT,
    output reg                      CMD_ISSUE_OUT,
    output reg  [`DCST_CMD_W-1:0]   DDR_CMD_OUT,
    output reg  [13:0]              DDR_ADDR_OUT,
    output reg                      DDR_CKE_OUT,
    output reg                      DDR_CLK_EN_OUT,
    output reg                      ODT_SYNC_OK_OUT,
    output reg                      SLOW_EXIT_OUT
);
    // ------------------------------------------------------------
    // Grade, additive latency and refresh time dependent figures
    // ------------------------------------------------------------
    function [7:0] pick;
        input [1:0] grade;
        input [7:0] fast;
        input [7:0] slow;
        begin
            pick = (grade < `DCST_GRADE_SLOW) ? fast : slow;
        end
    endfunction

    localparam [7:0] XSNR_ADD =
        (`DCST_XSNR_ADD_NS + `DCST_CLK_NS - 1) / `DCST_CLK_NS;

    wire [7:0] wtr   = pick(GRADE_IN, `DCST_WTR_FAST, `DCST_WTR_SLOW);
    wire [7:0] rtp   = pick(GRADE_IN, `DCST_RTP_FAST, `DCST_RTP_SLOW);
    wire [7:0] wr    = (GRADE_IN == `DCST_GRADE_SLOWEST) ? `DCST_WR_SLOWEST
                                          : `DCST_WR_FAST;
    wire [7:0] xards = (`DCST_XARDS_BASE > {5'h00, AL_IN}) ?
                       `DCST_XARDS_BASE - {5'h00, AL_IN} : 8'h01;
    wire [7:0] xsnr  = RFC_CYC_IN + XSNR_ADD;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire [3:0] c     = CMD_IN;
    wire is_rd   = c == `DCST_CMD_READ;
    wire is_wr   = c == `DCST_CMD_WRITE || c == `DCST_CMD_WRITE_AP;
    wire is_col  = is_rd || is_wr;
    wire is_pre  = c == `DCST_CMD_PRE;
    wire is_pde  = c == `DCST_CMD_PD_ENTER || c == `DCST_CMD_SR_ENTER;
    wire is_pdx  = c == `DCST_CMD_PD_EXIT || c == `DCST_CMD_SR_EXIT;
    wire is_wake = is_pdx || (c == `DCST_CMD_OTHER && !DDR_CKE_OUT);
    wire is_cke  = is_pde || is_wake;

    wire fire = CMD_VALID_IN && CMD_READY_OUT;
    wire issue_rd  = fire && is_rd;
    wire issue_wr  = fire && is_wr;
    wire issue_wap = fire && c == `DCST_CMD_WRITE_AP;
    wire issue_mrs = fire && c == `DCST_CMD_MRS;
    wire issue_odt = fire && c == `DCST_CMD_ODT;
    wire issue_sx  = fire && c == `DCST_CMD_SR_EXIT;
    wire issue_px  = fire && c == `DCST_CMD_PD_EXIT;
    wire issue_cke = fire && is_cke;

    // ------------------------------------------------------------
    // Countdowns
    // ------------------------------------------------------------
    localparam N = 12;
    localparam K_CCD = 0;
    localparam K_WTR = 1;
    localparam K_RTP = 2;
    localparam K_DAL = 3;
    localparam K_SNR = 4;
    localparam K_SRD = 5;
    localparam K_XP  = 6;
    localparam K_XRD = 7;
    localparam K_CKE = 8;
    localparam K_NPD = 9;
    localparam K_XPD = 10;
    localparam K_MRD = 11;

    reg  slow_exit_r;
    reg  wr_pend_r;
    wire [N-1:0] ld;
    wire [N-1:0] done;
    wire [8*N-1:0] val;

    assign ld[K_CCD]  = fire && is_col;
    assign val[7:0]   = `DCST_CCD;
    assign ld[K_WTR]  = wr_pend_r && WDATA_LAST_IN;
    assign val[15:8]  = wtr;
    assign ld[K_RTP]  = issue_rd;
    assign val[23:16] = rtp;
    assign ld[K_DAL]  = issue_wap;
    assign val[31:24] = wr + RFC_CYC_IN[3:0];
    assign ld[K_SNR]  = issue_sx;
    assign val[39:32] = xsnr;
    assign ld[K_SRD]  = issue_sx;
    assign val[47:40] = `DCST_XSRD;
    assign ld[K_XP]   = issue_px;
    assign val[55:48] = `DCST_XP;
    assign ld[K_XRD]  = issue_px && PD_ACTIVE_IN;
    assign val[63:56] = slow_exit_r ? xards : `DCST_XARD;
    assign ld[K_CKE]  = issue_cke;
    assign val[71:64] = `DCST_CKE_MIN;
    assign ld[K_NPD]  = issue_odt;
    assign val[79:72] = `DCST_ANPD;
    assign ld[K_XPD]  = issue_px || issue_sx;
    assign val[87:80] = `DCST_AXPD;
    assign ld[K_MRD]  = issue_mrs;
    assign val[95:88] = `DCST_MRD;

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_cnt
            dcst_counter u_cnt (
                .clk_in   (CLK_IN),
                .rst_n_in (RST_N_IN),
                .load_in  (ld[g]),
                .value_in (val[8*g+7:8*g]),
                .done_out (done[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Gate
    // ------------------------------------------------------------
    // Reads may pass the non-read self refresh wait, not the 200
    wire ok_rd  = done[K_CCD] && done[K_WTR] && done[K_SRD]
                  && done[K_XRD] && done[K_DAL];
    wire ok_any = done[K_SNR] && done[K_XP] && done[K_MRD]
                  && done[K_DAL];
    reg ok;
    always @* begin
        ok = done[K_MRD];
        if (is_rd) begin
            ok = ok_rd && done[K_MRD];
        end else begin
            ok = ok_any;
            if (is_col && !done[K_CCD]) ok = 1'b0;
            if (is_pre && !done[K_RTP]) ok = 1'b0;
            if (is_cke && !done[K_CKE]) ok = 1'b0;
            if (is_pde && !done[K_NPD]) ok = 1'b0;
            if (is_pdx) ok = done[K_CKE] && done[K_MRD];
        end
    end

    // ------------------------------------------------------------
    // Pin and status registers
    // ------------------------------------------------------------
    reg [7:0] hold_r;
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            CMD_READY_OUT   <= 1'b0;
            CMD_ISSUE_OUT   <= 1'b0;
            DDR_CMD_OUT     <= `DCST_CMD_NOP;
            DDR_ADDR_OUT    <= 14'h0000;
            DDR_CKE_OUT     <= 1'b0;
            DDR_CLK_EN_OUT  <= 1'b1;
            ODT_SYNC_OK_OUT <= 1'b0;
            SLOW_EXIT_OUT   <= 1'b0;
            slow_exit_r     <= 1'b0;
            wr_pend_r       <= 1'b0;
            hold_r          <= 8'h00;
        end else begin
            // Ready drops for one cycle after a fire so all gates re-evaluate
            CMD_READY_OUT <= CMD_VALID_IN && ok && !fire;
            CMD_ISSUE_OUT <= fire;
            DDR_CMD_OUT   <= fire ? CMD_IN : `DCST_CMD_NOP;
            DDR_ADDR_OUT  <= fire ? CMD_ADDR_IN : DDR_ADDR_OUT;
            if (fire && is_pde) DDR_CKE_OUT <= 1'b0;
            if (fire && is_pdx) DDR_CKE_OUT <= 1'b1;
            if (fire && c == `DCST_CMD_OTHER) DDR_CKE_OUT <= 1'b1;
            if (issue_mrs) begin
                slow_exit_r   <= CMD_ADDR_IN[`DCST_MR_PDX_BIT];
                SLOW_EXIT_OUT <= CMD_ADDR_IN[`DCST_MR_PDX_BIT];
            end
            if (issue_wr) wr_pend_r <= 1'b1;
            else if (WDATA_LAST_IN) wr_pend_r <= 1'b0;
            if (fire && is_pde) begin
                hold_r <= `DCST_HOLD_CYC;
            end else if (hold_r != 8'h00) begin
                hold_r <= hold_r - 8'h01;
            end
            // Wake restarts the clock on the edge that raises enable
            DDR_CLK_EN_OUT <= DDR_CKE_OUT || hold_r != 8'h00
                              || (fire && is_wake);
            ODT_SYNC_OK_OUT <= DDR_CKE_OUT && done[K_XPD]
                               && !ld[K_XPD];
        end
    end
endmodule // dcst_timer

`default_nettype wire

// >>> dcst_map.vh
// Timing constants and command codes for the command spacing timer
`ifndef DCST_MAP_VH
`define DCST_MAP_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define DCST_CMD_W        4
`define DCST_CMD_NOP      4'h0
`define DCST_CMD_READ     4'h1
`define DCST_CMD_WRITE    4'h2
`define DCST_CMD_WRITE_AP 4'h3
`define DCST_CMD_PRE      4'h4
`define DCST_CMD_MRS      4'h5
`define DCST_CMD_ODT      4'h6
`define DCST_CMD_PD_ENTER 4'h7
`define DCST_CMD_PD_EXIT  4'h8
`define DCST_CMD_SR_ENTER 4'h9
`define DCST_CMD_SR_EXIT  4'hA
`define DCST_CMD_OTHER    4'hB

// ----------------------------------------------------------------
// Spacing figures in device clock cycles; margin and clock period in ns
// ----------------------------------------------------------------
`define DCST_CNT_W        8
`define DCST_CCD          8'h02
`define DCST_WTR_FAST     8'h04
`define DCST_WTR_SLOW     8'h03
`define DCST_RTP_FAST     8'h04
`define DCST_RTP_SLOW     8'h03
`define DCST_WR_FAST      8'h06
`define DCST_WR_SLOWEST   8'h05
`define DCST_XSRD         8'hC8
`define DCST_XP           8'h02
`define DCST_XARD         8'h02
`define DCST_XARDS_BASE   8'h06
`define DCST_CKE_MIN      8'h03
`define DCST_ANPD         8'h03
`define DCST_AXPD         8'h08
`define DCST_MRD          8'h02
// Margin added to refresh cycle time on self refresh exit, in ns
`define DCST_XSNR_ADD_NS  10
`define DCST_CLK_NS       8
// Clock held after an asynchronous enable drop: setup+period+hold
`define DCST_HOLD_CYC     8'h03

// ----------------------------------------------------------------
// Speed grades, fastest first
// ----------------------------------------------------------------
`define DCST_GRADE_W      2
// Grade codes from this one on use the slower write to read and read to precharge figures
`define DCST_GRADE_SLOW    2'h2
`define DCST_GRADE_SLOWEST 2'h3
`define DCST_MR_PDX_BIT   12

`endif

// >>> dcst_counter.v
// Loadable countdown used for each spacing constraint
`timescale 1ns/1ps
`default_nettype none
`include "dcst_map.vh"

module dcst_counter (
    input  wire                   clk_in,
    input  wire                   rst_n_in,
    input  wire                   load_in,
    input  wire [`DCST_CNT_W-1:0] value_in,
    output wire                   done_out
);
    reg [`DCST_CNT_W-1:0] cnt_r;

    // Load of value N releases the dependent command N cycles later
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= 8'h00;
        end else if (load_in) begin
            cnt_r <= (value_in > 8'h01) ? value_in - 8'h01 : 8'h00;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    assign done_out = (cnt_r == 8'h00) && !load_in;
endmodule // dcst_counter

`default_nettype wire

// >>> dcst_timer_sva.sv
// Checker for the command spacing timer
`timescale 1ns/1ps
`default_nettype none
`include "dcst_map.vh"
module dcst_timer_sva (
    input wire logic                     CLK_IN,
    input wire logic                     RST_N_IN,
    input wire logic [`DCST_GRADE_W-1:0] GRADE_IN,
    input wire logic                     CMD_VALID_IN,
    input wire logic [`DCST_CMD_W-1:0]   CMD_IN,
    input wire logic                     WDATA_LAST_IN,
    input wire logic                     CMD_READY_OUT,
    input wire logic                     CMD_ISSUE_OUT,
    input wire logic [`DCST_CMD_W-1:0]   DDR_CMD_OUT,
    input wire logic [13:0]              DDR_ADDR_OUT,
    input wire logic                     DDR_CKE_OUT,
    input wire logic                     DDR_CLK_EN_OUT,
    input wire logic                     ODT_SYNC_OK_OUT,
    input wire logic                     SLOW_EXIT_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Saturating ages, so idle time never wraps into a false gap
    logic [7:0] wd_cnt_r;
    logic [7:0] sr_cnt_r;
    wire take = CMD_VALID_IN && CMD_READY_OUT;
    wire is_rd = CMD_ISSUE_OUT && DDR_CMD_OUT == `DCST_CMD_READ;
    wire is_mrs = CMD_ISSUE_OUT && DDR_CMD_OUT == `DCST_CMD_MRS;
    wire is_srx = CMD_ISSUE_OUT && DDR_CMD_OUT == `DCST_CMD_SR_EXIT;
    wire is_pdx = CMD_ISSUE_OUT && DDR_CMD_OUT == `DCST_CMD_PD_EXIT;
    wire mrs_bit = DDR_ADDR_OUT[`DCST_MR_PDX_BIT];
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wd_cnt_r <= 8'hFF;
            sr_cnt_r <= 8'hFF;
        end else begin
            if (WDATA_LAST_IN) wd_cnt_r <= 8'h00;
            else if (wd_cnt_r != 8'hFF) wd_cnt_r <= wd_cnt_r + 8'h01;
            if (is_srx) sr_cnt_r <= 8'h00;
            else if (sr_cnt_r != 8'hFF) sr_cnt_r <= sr_cnt_r + 8'h01;
        end
    end
    take_answer_a: assert property (take |=> CMD_ISSUE_OUT
        && DDR_CMD_OUT == $past(CMD_IN)) else $error("answer wrong");
    ready_drop_a: assert property (take |=> !CMD_READY_OUT)
        else $error("ready held after take");
    issue_pulse_a: assert property (CMD_ISSUE_OUT |=> !CMD_ISSUE_OUT
        && DDR_CMD_OUT == `DCST_CMD_NOP) else $error("issue too long");
    wtr_gap_a: assert property (is_rd |-> wd_cnt_r >=
        (GRADE_IN < `DCST_GRADE_SLOW ? 8'h04 : 8'h03))
        else $error("read after write early");
    srx_read_a: assert property (is_rd |-> sr_cnt_r >= 8'hC7)
        else $error("read after self refresh early");
    cke_hold_a: assert property ($changed(DDR_CKE_OUT) |=>
        $stable(DDR_CKE_OUT) [*2]) else $error("enable pulse short");
    clk_hold_a: assert property ($fell(DDR_CKE_OUT) |->
        DDR_CLK_EN_OUT [*3]) else $error("clock stopped early");
    odt_wait_a: assert property (is_pdx |-> !ODT_SYNC_OK_OUT [*7])
        else $error("termination ready early");
    slow_copy_a: assert property (is_mrs |=>
        SLOW_EXIT_OUT == $past(mrs_bit)) else $error("exit mode wrong");
    cover property (is_rd);
    cover property (is_srx);
    cover property (is_mrs ##1 SLOW_EXIT_OUT);
endmodule // dcst_timer_sva
bind dcst_timer dcst_timer_sva chk (.CLK_IN, .RST_N_IN, .GRADE_IN,
    .CMD_VALID_IN, .CMD_IN, .WDATA_LAST_IN, .CMD_READY_OUT, .CMD_ISSUE_OUT,
    .DDR_CMD_OUT, .DDR_ADDR_OUT, .DDR_CKE_OUT, .DDR_CLK_EN_OUT,
    .ODT_SYNC_OK_OUT, .SLOW_EXIT_OUT);
`default_nettype wire

// >>> dcst_dev_model.sv
// Behavioural device model driven by the timer
`timescale 1ns/1ps
`default_nettype none
`include "dcst_map.vh"
module dcst_dev_model (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        issue_in,
    input  wire logic [3:0]  cmd_in,
    input  wire logic [13:0] addr_in,
    output var  logic        slow_mode_out
);
    // Only the exit mode is kept; array contents are out of scope
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) slow_mode_out <= 1'b0;
        // State shows one clock after the command, inside the drive window
        else if (issue_in && cmd_in == `DCST_CMD_MRS)
            slow_mode_out <= addr_in[12];
    end
endmodule // dcst_dev_model
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the command spacing timer
`timescale 1ns/1ps
`default_nettype none
`include "dcst_map.vh"
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        valid = 1'b0;
    logic [3:0]  cmd = 4'h0;
    logic [13:0] addr = 14'h0000;
    logic        wlast = 1'b0;
    logic [1:0]  grade = 2'h0;
    logic        pd_act = 1'b1;
    logic        ready, issue, cke, clk_en, odt_ok, slow, dev_slow;
    logic [3:0]  ddr_cmd;
    logic [13:0] ddr_addr;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          t_iss, t_wl, t0;
    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    dcst_timer uut (.CLK_IN(clk), .RST_N_IN(rst_n), .GRADE_IN(grade),
        .AL_IN(3'h2), .RFC_CYC_IN(8'h13), .CMD_VALID_IN(valid),
        .CMD_IN(cmd), .CMD_ADDR_IN(addr), .PD_ACTIVE_IN(pd_act),
        .WDATA_LAST_IN(wlast), .CMD_READY_OUT(ready), .CMD_ISSUE_OUT(issue),
        .DDR_CMD_OUT(ddr_cmd), .DDR_ADDR_OUT(ddr_addr), .DDR_CKE_OUT(cke),
        .DDR_CLK_EN_OUT(clk_en), .ODT_SYNC_OK_OUT(odt_ok),
        .SLOW_EXIT_OUT(slow));
    dcst_dev_model dev (.clk_in(clk), .rst_n_in(rst_n), .issue_in(issue),
        .cmd_in(ddr_cmd), .addr_in(ddr_addr), .slow_mode_out(dev_slow));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task check(input string what, input logic [15:0] seen,
               input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task gap(input string what, input int from, input int least);
        check(what, {15'h0, (t_iss - from) >= least}, 16'h0001);
    endtask
    // Request held until taken; answer looked at one cycle later
    task send(input logic [3:0] c, input logic [13:0] a);
        int k;
        k = 0;
        valid <= 1'b1;
        cmd <= c;
        addr <= a;
        @(posedge clk);
        while (ready !== 1'b1 && k < 400) begin
            k++;
            @(posedge clk);
        end
        valid <= 1'b0;
        @(posedge clk);
        t_iss = cyc;
        check("issue", {15'h0, issue}, 16'h0001);
        check("command", {12'h0, ddr_cmd}, {12'h0, c});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_col;
        send(`DCST_CMD_OTHER, 14'h0000);
        send(`DCST_CMD_WRITE, 14'h0000);
        wlast <= 1'b1;
        @(posedge clk);
        t_wl = cyc;
        wlast <= 1'b0;
        send(`DCST_CMD_READ, 14'h0000);
        gap("write to read", t_wl, 4);
        t0 = t_iss;
        send(`DCST_CMD_READ, 14'h0008);
        gap("column gap", t0, 2);
        t0 = t_iss;
        send(`DCST_CMD_PRE, 14'h0000);
        gap("read to precharge", t0, 4);
        send(`DCST_CMD_WRITE_AP, 14'h0000);
        t0 = t_iss;
        send(`DCST_CMD_READ, 14'h0000);
        gap("recovery", t0, 9);
        $display("test column done");
    endtask
    task t_mrs;
        send(`DCST_CMD_MRS, 14'h1000);
        t0 = t_iss;
        check("slow exit", {15'h0, slow}, 16'h0001);
        send(`DCST_CMD_OTHER, 14'h0000);
        gap("mode set gap", t0, 2);
        // Model registers the issue pulse, so look one command later
        check("device mode", {15'h0, dev_slow}, 16'h0001);
        $display("test mode done");
    endtask
    task t_pd;
        send(`DCST_CMD_ODT, 14'h0000);
        t0 = t_iss;
        send(`DCST_CMD_PD_ENTER, 14'h0000);
        gap("odt to power down", t0, 3);
        t0 = t_iss;
        check("cke low", {15'h0, cke}, 16'h0000);
        repeat (2) @(posedge clk);
        check("clock held", {15'h0, clk_en}, 16'h0001);
        repeat (4) @(posedge clk);
        check("clock stopped", {15'h0, clk_en}, 16'h0000);
        send(`DCST_CMD_PD_EXIT, 14'h0000);
        gap("cke low width", t0, 3);
        check("clock back", {15'h0, clk_en}, 16'h0001);
        check("odt early", {15'h0, odt_ok}, 16'h0000);
        t0 = t_iss;
        send(`DCST_CMD_READ, 14'h0000);
        gap("slow exit read", t0, 4);
        check("odt wait", {15'h0, odt_ok}, 16'h0000);
        repeat (10) @(posedge clk);
        check("odt ready", {15'h0, odt_ok}, 16'h0001);
        $display("test power down done");
    endtask
    task t_sr;
        send(`DCST_CMD_SR_ENTER, 14'h0000);
        send(`DCST_CMD_SR_EXIT, 14'h0000);
        t0 = t_iss;
        send(`DCST_CMD_READ, 14'h0000);
        gap("self refresh read", t0, 200);
        send(`DCST_CMD_SR_ENTER, 14'h0000);
        send(`DCST_CMD_SR_EXIT, 14'h0000);
        t0 = t_iss;
        send(`DCST_CMD_PRE, 14'h0000);
        gap("self refresh other", t0, 21);
        $display("test self refresh done");
    endtask
    task t_fast;
        send(`DCST_CMD_MRS, 14'h0000);
        check("fast exit", {15'h0, slow}, 16'h0000);
        send(`DCST_CMD_PD_ENTER, 14'h0000);
        send(`DCST_CMD_PD_EXIT, 14'h0000);
        t0 = t_iss;
        send(`DCST_CMD_READ, 14'h0000);
        gap("fast exit read", t0, 2);
        pd_act <= 1'b0;
        send(`DCST_CMD_PD_ENTER, 14'h0000);
        send(`DCST_CMD_PD_EXIT, 14'h0000);
        t0 = t_iss;
        send(`DCST_CMD_PRE, 14'h0000);
        gap("precharge exit", t0, 2);
        pd_act <= 1'b1;
        $display("test fast exit done");
    endtask
    task t_slow;
        grade <= 2'h3;
        send(`DCST_CMD_WRITE, 14'h0000);
        wlast <= 1'b1;
        @(posedge clk);
        t_wl = cyc;
        wlast <= 1'b0;
        send(`DCST_CMD_READ, 14'h0000);
        gap("slow write to read", t_wl, 3);
        t0 = t_iss;
        send(`DCST_CMD_PRE, 14'h0000);
        gap("slow read to precharge", t0, 3);
        send(`DCST_CMD_WRITE_AP, 14'h0000);
        t0 = t_iss;
        send(`DCST_CMD_READ, 14'h0000);
        gap("slow recovery", t0, 8);
        grade <= 2'h0;
        $display("test slow grade done");
    endtask
    task results;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #40000;
        n_mismatch++;
        results;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_col;
        t_mrs;
        t_pd;
        t_fast;
        t_slow;
        t_sr;
        results;
    end
endmodule // tb
`default_nettype wire
